// file: rtl/ptr_reader_ctl.sv
/*
  paper tape reader input control: decodes commands, drives the reader
  motor, captures frames into the input buffer register, serves external
  reads with lockout, and flags overrun faults.
  assumes the photocell frame and its strobe arrive from pins; command
  and read requests come from logic on mclk_i.
*/
`timescale 1ns/10ps
`default_nettype none
`include "ptr_map.svh"
module ptr_reader_ctl
  import ptr_pkg::*;
#(
  parameter int FRAME_BITS = `PTR_FRAME_BITS,
  parameter int FRAME_CYC = `PTR_FRAME_CYC,
  parameter int HOLD_CYC = `PTR_HOLD_CYC,
  parameter int START_CYC = `PTR_START_CYC
) (
  input wire logic mclk_i,
  input wire logic reset_i,
  input wire logic clk_en_i,
  input wire logic cmd_valid_i,
  input wire logic [`PTR_CMD_WIDTH-1:0] cmd_word_i,
  input wire logic read_req_i,
  input wire logic [FRAME_BITS-1:0] frame_i,
  input wire logic frame_strobe_i,
  input wire logic fault_clear_i,
  output logic motor_on_o,
  output logic [FRAME_BITS-1:0] input_buffer_register_o,
  output logic [FRAME_BITS-1:0] exchange_o,
  output logic read_done_o,
  output logic lockout_o,
  output logic io_fault_o,
  output logic halt_o
);
  localparam int CW = 17;
  // refuse parameter values the logic cannot serve
  if (FRAME_BITS < 6 || FRAME_BITS > 7) begin : g_bad_frame
    $error("frame must be 6 or 7");
  end
  if (FRAME_CYC < 1 || HOLD_CYC < 1 || START_CYC < 1) begin : g_bad_count
    $error("bad count");
  end
  if (FRAME_CYC >= 2**CW || HOLD_CYC >= 2**CW ||
      START_CYC >= 2**CW) begin : g_wide_count
    $error("count too wide");
  end

  // pin inputs through two flops; strobe edge taken after sync
  logic [FRAME_BITS:0] pin_s;
  ptr_sync #(.W(FRAME_BITS + 1)) u_sync (
    .mclk_i(mclk_i),
    .reset_i(reset_i),
    .en_i(clk_en_i),
    .d_i({frame_strobe_i, frame_i}),
    .q_o(pin_s)
  );

  ptr_cmd_s cmd;
  logic cmd_sel;
  logic strobe_s;
  logic strobe_last_q;
  logic strobe_last_d;
  logic frame_ev;
  ptr_state_e state_q;
  ptr_state_e state_d;
  logic [CW-1:0] cnt_q;
  logic [CW-1:0] cnt_d;
  logic step_q;
  logic step_d;
  logic pend_start_q;
  logic pend_start_d;
  logic pend_step_q;
  logic pend_step_d;
  logic [FRAME_BITS-1:0] buf_q;
  logic [FRAME_BITS-1:0] buf_d;
  logic full_q;
  logic full_d;
  logic [FRAME_BITS-1:0] xch_q;
  logic [FRAME_BITS-1:0] xch_d;
  logic wait_q;
  logic wait_d;
  logic done_q;
  logic done_d;
  logic fault_q;
  logic fault_d;
  logic deliver;

  // command fields; select gates every action [R4] [R19]
  assign cmd.sel = cmd_word_i[`PTR_SEL_BIT];
  assign cmd.start = cmd_word_i[`PTR_START_BIT];
  assign cmd.stop = cmd_word_i[`PTR_STOP_BIT];
  assign cmd_sel = cmd_valid_i && cmd.sel;
  assign strobe_s = pin_s[FRAME_BITS];
  assign frame_ev = strobe_s && !strobe_last_q;
  // frames reach the buffer only while the motor turns
  assign deliver = frame_ev && (state_q == PTR_RUN || state_q == PTR_LAST);

  // reader sequencing: hold-off, spin-up, run, last frame
  always_comb begin
    state_d = state_q;
    cnt_d = cnt_q;
    step_d = step_q;
    pend_start_d = pend_start_q;
    pend_step_d = pend_step_q;
    strobe_last_d = strobe_s;
    if (cnt_q != '0) cnt_d = cnt_q - 1'b1;
    unique case (state_q)
      PTR_IDLE: begin
        if (cmd_sel && cmd.start) begin
          state_d = PTR_SPINUP; // start delay [R16]
          cnt_d = CW'(START_CYC);
          step_d = cmd.stop; // both bits mean step [R7]
        end
      end
      PTR_HOLD: begin
        if (cmd_sel && cmd.start) begin
          pend_start_d = 1'b1; // deferred restart [R15]
          pend_step_d = cmd.stop;
        end
        if (cnt_q == '0 && pend_start_q) begin
          state_d = PTR_SPINUP;
          cnt_d = CW'(START_CYC);
          step_d = pend_step_q;
          pend_start_d = 1'b0;
        end else if (cnt_q == '0) begin
          state_d = PTR_IDLE;
        end
      end
      PTR_SPINUP: begin
        if (cmd_sel && cmd.stop && !cmd.start) step_d = 1'b1;
        if (cnt_q == '0) begin
          // step and pending stop both take one more frame [R6] [R7]
          state_d = step_q ? PTR_LAST : PTR_RUN; // free run [R5]
          cnt_d = CW'(FRAME_CYC);
        end
      end
      PTR_RUN: begin
        if (cmd_sel && cmd.stop && !cmd.start) begin
          state_d = PTR_LAST; // halt after next sensed frame [R6]
        end
      end
      PTR_LAST: begin
        if (deliver) begin
          state_d = PTR_HOLD; // stop hold-off [R15]
          cnt_d = CW'(HOLD_CYC);
          pend_start_d = 1'b0;
        end
      end
    endcase
  end

  // buffer, exchange, lockout and fault
  always_comb begin
    buf_d = buf_q;
    full_d = full_q;
    xch_d = xch_q;
    wait_d = wait_q;
    done_d = 1'b0;
    fault_d = fault_q;
    if (fault_clear_i) fault_d = 1'b0;
    if (read_req_i && !wait_q && full_q) begin
      xch_d = buf_q; // copy first, then clear [R9]
      buf_d = '0;
      full_d = 1'b0;
      done_d = 1'b1;
    end else if (read_req_i && !wait_q) begin
      wait_d = 1'b1; // lockout until frame arrives [R10]
    end
    if (deliver) begin
      // only punched levels set stages [R1] [R2]
      buf_d = buf_d | pin_s[FRAME_BITS-1:0];
      full_d = 1'b1; // frame cancels pending lockout [R18]
      // a waiting read takes the old frame this cycle: no overrun
      if (full_q && !done_d && !wait_q) begin
        fault_d = 1'b1; // overrun; set beats clear [R11] [R14]
      end
    end
    if (wait_q && full_q) begin
      xch_d = buf_q; // resume waiting read [R10]
      buf_d = deliver ? pin_s[FRAME_BITS-1:0] : '0;
      full_d = deliver;
      wait_d = 1'b0;
      done_d = 1'b1;
    end
  end

  // register all state; clock enable freezes it
  always_ff @(posedge mclk_i or posedge reset_i) begin
    if (reset_i) begin
      state_q <= PTR_IDLE;
      cnt_q <= '0;
      step_q <= 1'b0;
      pend_start_q <= 1'b0;
      pend_step_q <= 1'b0;
      strobe_last_q <= 1'b0;
      buf_q <= '0;
      full_q <= 1'b0;
      xch_q <= '0;
      wait_q <= 1'b0;
      done_q <= 1'b0;
      fault_q <= 1'b0;
    end else if (clk_en_i) begin
      state_q <= state_d;
      cnt_q <= cnt_d;
      step_q <= step_d;
      pend_start_q <= pend_start_d;
      pend_step_q <= pend_step_d;
      strobe_last_q <= strobe_last_d;
      buf_q <= buf_d;
      full_q <= full_d;
      xch_q <= xch_d;
      wait_q <= wait_d;
      done_q <= done_d;
      fault_q <= fault_d;
    end
  end

  // outputs straight from flops; frame pacing is the mechanism's [R8]
  logic motor_q;
  always_ff @(posedge mclk_i or posedge reset_i) begin
    if (reset_i) begin
      motor_q <= 1'b0;
    end else if (clk_en_i) begin
      motor_q <= (state_d == PTR_SPINUP || state_d == PTR_RUN ||
                  state_d == PTR_LAST);
    end
  end
  assign motor_on_o = motor_q;
  assign input_buffer_register_o = buf_q;
  assign exchange_o = xch_q;
  assign read_done_o = done_q;
  assign lockout_o = wait_q;
  assign io_fault_o = fault_q;
  assign halt_o = fault_q;
endmodule
`default_nettype wire

// file: rtl/ptr_map.svh
/*
  constants for the paper tape reader input control: command stage
  positions, frame width and timing counts.
  assumes a 10 mhz mclk_i; times are given in microseconds.
*/
// How it works
// R1 - frame bits land together in low buffer stages
// R2 - delivery only sets stages, never clears them
// R3 - host reads once per delivered frame
// R4 - commands act only with select stage set
// R5 - start bit alone means free run
// R6 - stop halts after next sensed frame
// R7 - step delivers exactly one frame, then stops
// R8 - free run spaces frames 4.3 to 5 ms
// R9 - read copies buffer to exchange, then clears
// R10 - early read waits in lockout for frame
// R11 - frame onto unread buffer raises io fault
// R12 - host stops early to pick last frame
// R13 - host reads final frame after stop
// R14 - late stop extra frame faults and halts
// R15 - stop hold-off of 3 ms defers restart
// R16 - start adds about 1 ms delay
// R17 - host reads after each step command
// R18 - frame before read cancels pending lockout
// R19 - unselected command leaves reader state unchanged
`ifndef PTR_MAP_SVH
`define PTR_MAP_SVH
`define PTR_CMD_WIDTH 36
`define PTR_SEL_BIT 33
`define PTR_START_BIT 16
`define PTR_STOP_BIT 15
`define PTR_FRAME_BITS 7
`define PTR_CLK_KHZ 10000
`define PTR_FRAME_US 4300
`define PTR_HOLD_US 3000
`define PTR_START_US 1000
`define PTR_FRAME_CYC ((`PTR_FRAME_US * `PTR_CLK_KHZ + 999) / 1000)
`define PTR_HOLD_CYC ((`PTR_HOLD_US * `PTR_CLK_KHZ + 999) / 1000)
`define PTR_START_CYC ((`PTR_START_US * `PTR_CLK_KHZ + 999) / 1000)
`endif

// file: rtl/ptr_pkg.sv
/*
  types for the paper tape reader input control.
  assumes ptr_map.svh for widths.
*/
`include "ptr_map.svh"
package ptr_pkg;
  typedef enum logic [2:0] {
    PTR_IDLE, PTR_HOLD, PTR_SPINUP, PTR_RUN, PTR_LAST
  } ptr_state_e;
  typedef struct packed {
    logic sel;
    logic start;
    logic stop;
  } ptr_cmd_s;
  typedef logic [`PTR_FRAME_BITS-1:0] ptr_frame_t;
endpackage

// file: rtl/ptr_sync.sv
/*
  two-flop synchroniser for pin-level inputs of the reader control.
  assumes a single clock; en_i freezes state.
*/
`timescale 1ns/10ps
`default_nettype none
module ptr_sync #(
  parameter int W = 8
) (
  input wire logic mclk_i,
  input wire logic reset_i,
  input wire logic en_i,
  input wire logic [W-1:0] d_i,
  output logic [W-1:0] q_o
);
  logic [W-1:0] s1_q;
  logic [W-1:0] s1_d;
  logic [W-1:0] s2_q;
  logic [W-1:0] s2_d;
  // hold both stages while disabled
  always_comb begin
    s1_d = en_i ? d_i : s1_q;
    s2_d = en_i ? s1_q : s2_q;
  end
  // register the two stages
  always_ff @(posedge mclk_i or posedge reset_i) begin
    if (reset_i) begin
      s1_q <= '0;
      s2_q <= '0;
    end else begin
      s1_q <= s1_d;
      s2_q <= s2_d;
    end
  end
  assign q_o = s2_q;
endmodule
`default_nettype wire

// file: testbench/ptr_properties.sv
/*
  port assertions for the reader control.
  assumes frames that are never all zero; checks pause while clk_en_i
  is low, since all state is frozen then.
*/
`timescale 1ns/10ps
`default_nettype none
`include "ptr_map.svh"
module ptr_properties #(
  parameter int HOLD_CYC = 10
) (
  input wire logic mclk_i,
  input wire logic reset_i,
  input wire logic clk_en_i,
  input wire logic cmd_valid_i,
  input wire logic [`PTR_CMD_WIDTH-1:0] cmd_word_i,
  input wire logic read_req_i,
  input wire logic fault_clear_i,
  input wire logic motor_on_o,
  input wire logic [`PTR_FRAME_BITS-1:0] input_buffer_register_o,
  input wire logic [`PTR_FRAME_BITS-1:0] exchange_o,
  input wire logic read_done_o,
  input wire logic lockout_o,
  input wire logic io_fault_o,
  input wire logic halt_o
);
  default clocking @(posedge mclk_i); endclocking
  default disable iff (reset_i || !clk_en_i);
  logic [7:0] idle_q, idle_d;
  // cycles spent with the motor off, saturating
  always_comb begin
    idle_d = idle_q;
    if (motor_on_o) idle_d = 8'h00;
    else if (idle_q != 8'hff) idle_d = idle_q + 8'h01;
  end
  always_ff @(posedge mclk_i or posedge reset_i) begin
    if (reset_i) idle_q <= 8'h00;
    else idle_q <= idle_d;
  end
  // a new read, not already waiting
  sequence s_read_new;
    $rose(read_req_i) && !lockout_o && !read_done_o;
  endsequence
  // selected command while idle past the hold-off
  sequence s_sel_idle;
    cmd_valid_i && cmd_word_i[`PTR_SEL_BIT] && idle_q > HOLD_CYC + 3;
  endsequence
  AST_START_RUN: assert property (s_sel_idle ##0
    cmd_word_i[`PTR_START_BIT] |=> motor_on_o) else $error("no start");
  AST_SELECT: assert property (cmd_valid_i && !cmd_word_i[`PTR_SEL_BIT]
    && idle_q > HOLD_CYC + 3 |=> !motor_on_o) else $error("unselected");
  AST_HOLD_OFF: assert property ($fell(motor_on_o)
    |-> !motor_on_o [*8]) else $error("hold-off short");
  AST_HOLD_GAP: assert property ($rose(motor_on_o)
    |-> idle_q >= HOLD_CYC) else $error("restart inside hold-off");
  AST_READ_COPY: assert property (s_read_new ##0
    input_buffer_register_o != 7'h00 |=> read_done_o &&
    exchange_o == $past(input_buffer_register_o)) else $error("read copy");
  AST_READ_CLEAR: assert property ($rose(read_done_o)
    |-> input_buffer_register_o == 7'h00) else $error("buffer not cleared");
  AST_LOCK_SET: assert property (s_read_new ##0
    input_buffer_register_o == 7'h00 |=> lockout_o) else $error("no lockout");
  AST_LOCK_END: assert property (lockout_o &&
    input_buffer_register_o != 7'h00 |=> read_done_o && !lockout_o)
    else $error("lockout stuck");
  AST_DONE_PULSE: assert property (read_done_o |=> !read_done_o)
    else $error("done not a pulse");
  AST_FAULT_STICKY: assert property (io_fault_o && !fault_clear_i
    |=> io_fault_o) else $error("fault lost");
  AST_HALT_FAULT: assert property (halt_o == io_fault_o)
    else $error("halt differs");
endmodule
bind ptr_reader_ctl ptr_properties #(.HOLD_CYC(HOLD_CYC)) u_props (
  .mclk_i(mclk_i),
  .reset_i(reset_i),
  .clk_en_i(clk_en_i),
  .cmd_valid_i(cmd_valid_i),
  .cmd_word_i(cmd_word_i),
  .read_req_i(read_req_i),
  .fault_clear_i(fault_clear_i),
  .motor_on_o(motor_on_o),
  .input_buffer_register_o(input_buffer_register_o),
  .exchange_o(exchange_o),
  .read_done_o(read_done_o),
  .lockout_o(lockout_o),
  .io_fault_o(io_fault_o),
  .halt_o(halt_o)
);
`default_nettype wire

// file: testbench/ptr_tape_model.sv
/*
  tape mechanism model: one frame every PER cycles while the motor runs.
  assumes the reader control drives motor_on_o.
*/
`timescale 1ns/10ps
`default_nettype none
module ptr_tape_model #(
  parameter int PER = 20
) (
  input wire logic mclk_i,
  input wire logic reset_i,
  input wire logic motor_i,
  output logic [6:0] tape_frame_o,
  output logic tape_strobe_o
);
  int c;
  logic [6:0] seq;
  // all levels set together, fixed frame pace
  always @(posedge mclk_i or posedge reset_i) begin
    if (reset_i) begin
      c <= 0;
      seq <= 7'h01;
      tape_frame_o <= 7'h2a;
      tape_strobe_o <= 1'b0;
    end else begin
      c <= motor_i ? (c + 1) % PER : 0;
      tape_strobe_o <= motor_i && c >= 9 && c < 13;
      if (!motor_i || c == 17) tape_frame_o <= ~tape_frame_o;
      else if (c == 6) tape_frame_o <= seq;
      if (motor_i && c == 10) seq <= seq + 7'h01;
    end
  end
endmodule
`default_nettype wire

// file: testbench/ptr_reader_ctl_tb.sv
/*
  self-checking bench for the reader control: command table, free run,
  stop, step in the hold-off, overrun. assumes ptr_tape_model.
*/
`timescale 1ns/10ps
`default_nettype none
module ptr_reader_ctl_tb;
  logic mclk_i, reset_i, clk_en_i, cmd_valid_i, read_req_i;
  logic fault_clear_i, frame_strobe_i, motor_on_o, read_done_o;
  logic lockout_o, io_fault_o, halt_o;
  logic [35:0] cmd_word_i;
  logic [6:0] frame_i, input_buffer_register_o, exchange_o;
  int errors = 0;
  int checks_done = 0;
  int i;
  logic [36:0] rows [5] = '{{36'o100000200000, 1'b1},
    {36'o100000300000, 1'b1}, {36'o100000100000, 1'b0},
    {36'o000000200000, 1'b0}, {36'o000000300000, 1'b0}};
  ptr_reader_ctl #(.FRAME_CYC(20), .HOLD_CYC(10), .START_CYC(5)) uut (
    .mclk_i(mclk_i),
    .reset_i(reset_i),
    .clk_en_i(clk_en_i),
    .cmd_valid_i(cmd_valid_i),
    .cmd_word_i(cmd_word_i),
    .read_req_i(read_req_i),
    .frame_i(frame_i),
    .frame_strobe_i(frame_strobe_i),
    .fault_clear_i(fault_clear_i),
    .motor_on_o(motor_on_o),
    .input_buffer_register_o(input_buffer_register_o),
    .exchange_o(exchange_o),
    .read_done_o(read_done_o),
    .lockout_o(lockout_o),
    .io_fault_o(io_fault_o),
    .halt_o(halt_o)
  );
  ptr_tape_model #(.PER(20)) mdl (
    .mclk_i(mclk_i),
    .reset_i(reset_i),
    .motor_i(motor_on_o),
    .tape_frame_o(frame_i),
    .tape_strobe_o(frame_strobe_i)
  );
  // clock
  initial begin
    mclk_i = 1'b0;
    forever #50 mclk_i = ~mclk_i;
  end
  task automatic print_verdict;
    if (errors == 0 && checks_done > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  task automatic chk(input logic [6:0] g, input logic [6:0] e);
    checks_done++;
    if (g !== e) begin
      errors++;
      $display("Error at %0t: got %h exp %h", $time, g, e);
    end
  endtask
  task automatic tmo(input int n);
    if (i == n) begin
      errors++;
      print_verdict;
    end
  endtask
  task automatic do_reset;
    @(negedge mclk_i) reset_i = 1'b1;
    repeat (3) @(negedge mclk_i);
    reset_i = 1'b0;
    repeat (16) @(negedge mclk_i);
  endtask
  task automatic cmd(input logic [35:0] w);
    cmd_word_i = w;
    cmd_valid_i = 1'b1;
    @(negedge mclk_i) cmd_valid_i = 1'b0;
  endtask
  task automatic rd(input logic [6:0] e);
    read_req_i = 1'b1;
    for (i = 0; i < 99 && read_done_o !== 1'b1; i++) @(negedge mclk_i);
    read_req_i = 1'b0;
    tmo(99);
    chk(exchange_o, e);
    @(negedge mclk_i);
  endtask
  task automatic waitm(input logic v);
    for (i = 0; i < 199 && motor_on_o !== v; i++) @(negedge mclk_i);
    tmo(199);
  endtask
  // main sequence
  initial begin
    reset_i = 1'b1;
    clk_en_i = 1'b1;
    cmd_valid_i = 1'b0;
    read_req_i = 1'b0;
    fault_clear_i = 1'b0;
    cmd_word_i = 36'h0;
    do_reset;
    chk({motor_on_o, lockout_o, io_fault_o, halt_o, read_done_o}, 7'h00);
    chk(input_buffer_register_o, 7'h00);
    // command table
    foreach (rows[k]) begin
      do_reset;
      cmd(rows[k][36:1]);
      @(negedge mclk_i);
      chk(motor_on_o, rows[k][0]);
    end
    // free run in order, stop lets one more frame through
    do_reset;
    cmd(36'o100000200000);
    rd(7'h01);
    rd(7'h02);
    cmd(36'o100000100000);
    rd(7'h03);
    // step issued inside the hold-off
    cmd(36'o100000300000);
    chk(motor_on_o, 1'b0);
    waitm(1'b1);
    waitm(1'b0);
    rd(7'h04);
    repeat (40) @(negedge mclk_i);
    chk(input_buffer_register_o, 7'h00);
    chk(io_fault_o, 1'b0);
    // unread frames overrun the buffer
    cmd(36'o100000200000);
    repeat (60) @(negedge mclk_i);
    chk({io_fault_o, halt_o}, 7'h03);
    cmd(36'o100000100000);
    waitm(1'b0);
    fault_clear_i = 1'b1;
    @(negedge mclk_i) fault_clear_i = 1'b0;
    @(negedge mclk_i);
    chk(io_fault_o, 1'b0);
    // frames 05..08 landed unread: stages only ever set
    chk(input_buffer_register_o, 7'h0f);
    // clock enable low: a read request is not taken
    clk_en_i = 1'b0;
    read_req_i = 1'b1;
    repeat (4) @(negedge mclk_i);
    chk({lockout_o, read_done_o}, 7'h00);
    chk(input_buffer_register_o, 7'h0f);
    read_req_i = 1'b0;
    clk_en_i = 1'b1;
    @(negedge mclk_i);
    rd(7'h0f);
    chk(input_buffer_register_o, 7'h00);
    print_verdict;
  end
endmodule
`default_nettype wire
